// ---- include/usb_ep0_params.svh ----
// constants for the endpoint-0 control block and its host-side partner
// Operation
// - in count: four bits, reset zero
// - in NAK set answers IN with NAK
// - enable bit gates OUT completion interrupt; IN completion always raised
// - stall answers STALL, then clears itself
// - read-only toggle bit shows DATA0/DATA1
// - enable zero: OUT answered with NAK; IN still serviced
// - out count: four bits, upper bits zero
// - out NAK set refuses further OUT
// - seven-bit address; respond only when matching
// - firmware writes address after SET_ADDRESS
// - endpoint-0 buffer bases fixed in hardware
// - setup flag forces NAK on IN/OUT
`ifndef USB_EP0_PARAMS_SVH
`define USB_EP0_PARAMS_SVH

// firmware-side register addresses
`define EP0_IN_CFG_ADDR   16'hFF80
`define EP0_IN_BCNT_ADDR  16'hFF81
`define EP0_OUT_CFG_ADDR  16'hFF82
`define EP0_OUT_BCNT_ADDR 16'hFF83
`define FUNC_ADDR_ADDR    16'hFF93
`define DEV_IRQ_STAT_ADDR 16'hFF94
`define DEV_IRQ_MASK_ADDR 16'hFF95

// fixed buffer bases
`define EP0_IN_BUF_BASE   16'hFEF8
`define EP0_OUT_BUF_BASE  16'hFEF0

// field positions
`define NAK_BIT    7
`define BUFFER_MANAGER_ENABLE_BIT   7
`define TOG_BIT    5
`define STALL_BIT  3
`define IE_BIT     2
`define EP0_NUM    4'h0

// reset values
`define NAK_RESET  1'b1
`define CNT_RESET  4'h0
`define ADDR_RESET 7'h00

// device interrupt bits
`define DEV_IRQ_W  3
`define IRQ_SETUP  0
`define IRQ_OUT    1
`define IRQ_IN     2

// host AXI4-Lite word offsets
`define H_CMD_OFS  4'h0
`define H_STAT_OFS 4'h4
`define H_IST_OFS  4'h8
`define H_IMSK_OFS 4'hC

// host command word fields
`define CMD_PID_LO  0
`define CMD_TOG     2
`define CMD_EP_LO   3
`define CMD_ADDR_LO 7
`define CMD_LEN_LO  14

// host interrupt bits
`define HOST_IRQ_W 2
`define HIRQ_DONE  0
`define HIRQ_TMO   1

// cycles the host waits for an answer
`define TMO_CYCLES 5'd16
`define AXI_OKAY   2'h0
`define AXI_SLVERR 2'h2

`endif

// ---- include/usb_ep0_pkg.sv ----
// types shared by both ends of the endpoint-0 link
`default_nettype none
package usb_ep0_pkg;
  typedef enum logic [1:0] {
    PID_OUT   = 2'h0,
    PID_IN    = 2'h1,
    PID_SETUP = 2'h2,
    PID_HACK  = 2'h3
  } pid_t;
  typedef enum logic [1:0] {
    HS_ACK   = 2'h0,
    HS_NAK   = 2'h1,
    HS_STALL = 2'h2,
    HS_DATA  = 2'h3
  } code_t;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_TOKEN = 4'b0010,
    ST_WAIT  = 4'b0100,
    ST_HACK  = 4'b1000
  } host_state_t;
endpackage
`default_nettype wire

// ---- include/usb_link_if.sv ----
// token and answer link between host end and endpoint-0 end
`default_nettype none
interface usb_link_if (
  input wire logic aclk,
  input wire logic aresetn
);
  import usb_ep0_pkg::*;
  logic       tok_valid;
  pid_t       tok_pid;
  logic [6:0] tok_addr;
  logic [3:0] tok_ep;
  logic [3:0] tok_len;
  logic       tok_tog;
  logic       ans_valid;
  code_t      ans_code;
  logic [3:0] ans_len;
  logic       ans_tog;
  modport dev_end (
    input  tok_valid, tok_pid, tok_addr, tok_ep, tok_len, tok_tog,
    output ans_valid, ans_code, ans_len, ans_tog
  );
  modport host_end (
    output tok_valid, tok_pid, tok_addr, tok_ep, tok_len, tok_tog,
    input  ans_valid, ans_code, ans_len, ans_tog
  );
endinterface
`default_nettype wire

// ---- rtl/irq_sticky.sv ----
// sticky event bits, mask and one level interrupt
`include "usb_ep0_params.svh"
`default_nettype none
module irq_sticky #(
  parameter int N = 2
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [N-1:0] set,
  input  wire logic         clr_we,
  input  wire logic [N-1:0] clr_bits,
  input  wire logic         mask_we,
  input  wire logic [N-1:0] mask_bits,
  output logic      [N-1:0] status,
  output logic      [N-1:0] mask,
  output logic              irq
);
  logic [N-1:0] status_reg;
  logic [N-1:0] status_next;
  logic [N-1:0] mask_reg;
  logic [N-1:0] mask_next;

  // write one clears, but a new event in the same cycle wins
  always_comb begin
    status_next = status_reg;
    mask_next   = mask_reg;
    if (clr_we) begin
      status_next = status_reg & ~clr_bits;
    end
    status_next = status_next | set;
    if (mask_we) begin
      mask_next = mask_bits;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= '0;
      mask_reg   <= '0;
    end else begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
    end
  end

  assign status = status_reg;
  assign mask   = mask_reg;
  assign irq    = |(status_reg & mask_reg);
endmodule
`default_nettype wire

// ---- rtl/usb_ep0_dev.sv ----
// endpoint-0 control, byte count and function address end
//
// Chosen here: the simple firmware strobe port to the registers and the address map.
`include "usb_ep0_params.svh"
`default_nettype none
module usb_ep0_dev (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  usb_link_if.dev_end      link,
  input  wire logic [15:0] fw_addr,
  input  wire logic        fw_wr,
  input  wire logic        fw_rd,
  input  wire logic [7:0]  fw_wdata,
  output logic      [7:0]  fw_rdata,
  output logic      [15:0] buf_base,
  output logic             irq
);
  import usb_ep0_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // endpoint state
  logic        in_nak_reg;
  logic        in_nak_next;
  logic [3:0]  in_cnt_reg;
  logic [3:0]  in_cnt_next;
  logic        in_tog_reg;
  logic        in_tog_next;
  logic        in_pend_reg;
  logic        in_pend_next;
  logic        buffer_manager_enable_reg;
  logic        buffer_manager_enable_next;
  logic        ie_reg;
  logic        ie_next;
  logic        stall_reg;
  logic        stall_next;
  logic        tog_reg;
  logic        tog_next;
  logic        out_nak_reg;
  logic        out_nak_next;
  logic [3:0]  out_cnt_reg;
  logic [3:0]  out_cnt_next;
  logic [6:0]  fa_reg;
  logic [6:0]  fa_next;
  logic        ans_valid_reg;
  logic        ans_valid_next;
  code_t       ans_code_reg;
  code_t       ans_code_next;
  logic [3:0]  ans_len_reg;
  logic [3:0]  ans_len_next;
  logic        ans_tog_reg;
  logic        ans_tog_next;
  logic [15:0] buf_base_reg;
  logic [15:0] buf_base_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic [7:0]  rd_val;
  logic [`DEV_IRQ_W-1:0] evt;
  logic [`DEV_IRQ_W-1:0] irq_status;
  logic [`DEV_IRQ_W-1:0] irq_mask;
  logic        hit;
  logic        setup_flag;

  assign setup_flag = irq_status[`IRQ_SETUP];

  ////////////////////////////////////////////////////////////////////
  // next-state logic: firmware writes first, link events after them
  // so a hardware set in the same cycle wins over a firmware clear
  always_comb begin
    in_nak_next    = in_nak_reg;
    in_cnt_next    = in_cnt_reg;
    in_tog_next    = in_tog_reg;
    in_pend_next   = in_pend_reg;
    buffer_manager_enable_next      = buffer_manager_enable_reg;
    ie_next        = ie_reg;
    stall_next     = stall_reg;
    tog_next       = tog_reg;
    out_nak_next   = out_nak_reg;
    out_cnt_next   = out_cnt_reg;
    fa_next        = fa_reg;
    ans_valid_next = 1'b0;
    ans_code_next  = ans_code_reg;
    ans_len_next   = ans_len_reg;
    ans_tog_next   = ans_tog_reg;
    buf_base_next  = buf_base_reg;
    evt            = '0;
    hit = link.tok_valid && (link.tok_addr == fa_reg) && (link.tok_ep == `EP0_NUM);
    if (fw_wr) begin
      unique case (fw_addr)
        `EP0_IN_BCNT_ADDR: begin
          in_cnt_next = fw_wdata[3:0];
          in_nak_next = fw_wdata[`NAK_BIT];
        end
        `EP0_OUT_CFG_ADDR: begin
          buffer_manager_enable_next  = fw_wdata[`BUFFER_MANAGER_ENABLE_BIT];
          stall_next = fw_wdata[`STALL_BIT];
          ie_next    = fw_wdata[`IE_BIT];
        end
        `EP0_OUT_BCNT_ADDR: begin
          out_cnt_next = fw_wdata[3:0];
          out_nak_next = fw_wdata[`NAK_BIT];
        end
        `FUNC_ADDR_ADDR: fa_next = fw_wdata[6:0];
        default: ;
      endcase
    end
    if (hit) begin
      unique case (link.tok_pid)
        PID_SETUP: begin
          // setup raises the flag and restarts both toggles at DATA1
          evt[`IRQ_SETUP] = 1'b1;
          stall_next      = 1'b0;
          tog_next        = 1'b1;
          in_tog_next     = 1'b1;
          in_pend_next    = 1'b0;
          ans_valid_next  = 1'b1;
          ans_code_next   = HS_ACK;
        end
        PID_OUT: begin
          ans_valid_next = 1'b1;
          if (setup_flag) begin
            ans_code_next = HS_NAK;
          end else if (stall_reg) begin
            ans_code_next = HS_STALL;
            stall_next    = 1'b0;
          end else if (!buffer_manager_enable_reg || out_nak_reg) begin
            ans_code_next = HS_NAK;
          end else begin
            ans_code_next = HS_ACK;
            // a repeated packet is acknowledged but dropped
            if (link.tok_tog == tog_reg) begin
              out_cnt_next = link.tok_len;
              out_nak_next = 1'b1;
              tog_next = ~tog_reg;
              buf_base_next = `EP0_OUT_BUF_BASE;
              evt[`IRQ_OUT] = ie_reg;
            end
          end
        end
        PID_IN: begin
          ans_valid_next = 1'b1;
          if (setup_flag) begin
            ans_code_next = HS_NAK;
          end else if (stall_reg) begin
            ans_code_next = HS_STALL;
            stall_next    = 1'b0;
          end else if (in_nak_reg) begin
            ans_code_next = HS_NAK;
          end else begin
            ans_code_next = HS_DATA;
            ans_len_next  = in_cnt_reg;
            ans_tog_next  = in_tog_reg;
            in_pend_next  = 1'b1;
            buf_base_next = `EP0_IN_BUF_BASE;
          end
        end
        PID_HACK: begin
          if (in_pend_reg) begin
            in_nak_next   = 1'b1;
            in_tog_next   = ~in_tog_reg;
            in_pend_next  = 1'b0;
            evt[`IRQ_IN]  = 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // firmware read mux; reserved bits read as zero
  always_comb begin
    unique case (fw_addr)
      `EP0_IN_BCNT_ADDR:  rd_val = {in_nak_reg, 3'h0, in_cnt_reg};
      `EP0_OUT_CFG_ADDR:  rd_val = {buffer_manager_enable_reg, 1'b0, tog_reg, 1'b0, stall_reg, ie_reg, 2'h0};
      `EP0_OUT_BCNT_ADDR: rd_val = {out_nak_reg, 3'h0, out_cnt_reg};
      `FUNC_ADDR_ADDR:    rd_val = {1'b0, fa_reg};
      `DEV_IRQ_STAT_ADDR: rd_val = {5'h00, irq_status};
      `DEV_IRQ_MASK_ADDR: rd_val = {5'h00, irq_mask};
      default:            rd_val = 8'h00;
    endcase
    rdata_next = fw_rd ? rd_val : rdata_reg;
  end

  ////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_nak_reg    <= `NAK_RESET;
      in_cnt_reg    <= `CNT_RESET;
      in_tog_reg    <= 1'b0;
      in_pend_reg   <= 1'b0;
      buffer_manager_enable_reg      <= 1'b0;
      ie_reg        <= 1'b0;
      stall_reg     <= 1'b0;
      tog_reg       <= 1'b0;
      out_nak_reg   <= `NAK_RESET;
      out_cnt_reg   <= `CNT_RESET;
      fa_reg        <= `ADDR_RESET;
      ans_valid_reg <= 1'b0;
      ans_code_reg  <= HS_ACK;
      ans_len_reg   <= 4'h0;
      ans_tog_reg   <= 1'b0;
      buf_base_reg  <= `EP0_OUT_BUF_BASE;
      rdata_reg     <= 8'h00;
    end else begin
      in_nak_reg    <= in_nak_next;
      in_cnt_reg    <= in_cnt_next;
      in_tog_reg    <= in_tog_next;
      in_pend_reg   <= in_pend_next;
      buffer_manager_enable_reg      <= buffer_manager_enable_next;
      ie_reg        <= ie_next;
      stall_reg     <= stall_next;
      tog_reg       <= tog_next;
      out_nak_reg   <= out_nak_next;
      out_cnt_reg   <= out_cnt_next;
      fa_reg        <= fa_next;
      ans_valid_reg <= ans_valid_next;
      ans_code_reg  <= ans_code_next;
      ans_len_reg   <= ans_len_next;
      ans_tog_reg   <= ans_tog_next;
      buf_base_reg  <= buf_base_next;
      rdata_reg     <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // event flags and interrupt; setup bit doubles as the NAK override
  irq_sticky #(
    .N (`DEV_IRQ_W)
  ) u_irq (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .set       (evt),
    .clr_we    (fw_wr && (fw_addr == `DEV_IRQ_STAT_ADDR)),
    .clr_bits  (fw_wdata[`DEV_IRQ_W-1:0]),
    .mask_we   (fw_wr && (fw_addr == `DEV_IRQ_MASK_ADDR)),
    .mask_bits (fw_wdata[`DEV_IRQ_W-1:0]),
    .status    (irq_status),
    .mask      (irq_mask),
    .irq       (irq)
  );

  assign link.ans_valid = ans_valid_reg;
  assign link.ans_code  = ans_code_reg;
  assign link.ans_len   = ans_len_reg;
  assign link.ans_tog   = ans_tog_reg;
  assign fw_rdata       = rdata_reg;
  assign buf_base       = buf_base_reg;
endmodule
`default_nettype wire

// ---- rtl/usb_ep0_host.sv ----
// host-side transaction engine ordered over AXI4-Lite
`include "usb_ep0_params.svh"
`default_nettype none
module usb_ep0_host (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  usb_link_if.host_end     link,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq
);
  import usb_ep0_pkg::*;

  logic                   aw_held_reg, aw_held_next;
  logic [3:0]             awaddr_reg, awaddr_next;
  logic                   w_held_reg, w_held_next;
  logic [31:0]            wdata_reg, wdata_next;
  logic [3:0]             wstrb_reg, wstrb_next;
  logic                   bvalid_reg, bvalid_next;
  logic [1:0]             bresp_reg, bresp_next;
  logic                   rvalid_reg, rvalid_next;
  logic [31:0]            rdata_reg, rdata_next;
  logic [1:0]             rresp_reg, rresp_next;
  host_state_t            st_reg, st_next;
  logic [17:0]            cmd_reg, cmd_next;
  code_t                  code_reg, code_next;
  logic                   tmo_reg, tmo_next;
  logic [3:0]             rx_len_reg, rx_len_next;
  logic                   rx_tog_reg, rx_tog_next;
  logic [4:0]             wait_reg, wait_next;
  logic [31:0]            bmask;
  logic                   do_wr;
  logic [`HOST_IRQ_W-1:0] evt;
  logic [`HOST_IRQ_W-1:0] ist;
  logic [`HOST_IRQ_W-1:0] imsk;

  assign bmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign do_wr = aw_held_reg && w_held_reg;

  ////////////////////////////////////////////////////////////////////
  // bus slave: address and data caught in either order
  always_comb begin
    aw_held_next = aw_held_reg;
    awaddr_next  = awaddr_reg;
    w_held_next  = w_held_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg && !s_axi_bready;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg && !s_axi_rready;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (do_wr) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = (awaddr_reg == `H_STAT_OFS) ? `AXI_SLVERR : `AXI_OKAY;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = `AXI_OKAY;
      unique case (s_axi_araddr)
        `H_CMD_OFS:  rdata_next = {14'h0, cmd_reg};
        `H_STAT_OFS: rdata_next = {23'h0, rx_tog_reg, rx_len_reg, tmo_reg, code_reg,
                                   (st_reg != ST_IDLE)};
        `H_IST_OFS:  rdata_next = {30'h0, ist};
        `H_IMSK_OFS: rdata_next = {30'h0, imsk};
        default: begin
          rdata_next = 32'h0;
          rresp_next = `AXI_SLVERR;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // transaction sequencer; a command written while busy is dropped
  always_comb begin
    st_next     = st_reg;
    cmd_next    = cmd_reg;
    code_next   = code_reg;
    tmo_next    = tmo_reg;
    rx_len_next = rx_len_reg;
    rx_tog_next = rx_tog_reg;
    wait_next   = wait_reg;
    evt         = '0;
    unique case (st_reg)
      ST_IDLE: begin
        if (do_wr && (awaddr_reg == `H_CMD_OFS)) begin
          cmd_next = (cmd_reg & ~bmask[17:0]) | (wdata_reg[17:0] & bmask[17:0]);
          st_next  = ST_TOKEN;
        end
      end
      ST_TOKEN: begin
        wait_next = `TMO_CYCLES;
        st_next   = ST_WAIT;
      end
      ST_WAIT: begin
        if (link.ans_valid) begin
          code_next   = link.ans_code;
          tmo_next    = 1'b0;
          rx_len_next = link.ans_len;
          rx_tog_next = link.ans_tog;
          if (link.ans_code == HS_DATA) begin
            st_next = ST_HACK;
          end else begin
            evt[`HIRQ_DONE] = 1'b1;
            st_next         = ST_IDLE;
          end
        end else if (wait_reg == 5'd0) begin
          tmo_next        = 1'b1;
          evt[`HIRQ_TMO]  = 1'b1;
          st_next         = ST_IDLE;
        end else begin
          wait_next = wait_reg - 5'd1;
        end
      end
      ST_HACK: begin
        evt[`HIRQ_DONE] = 1'b1;
        st_next         = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= 4'h0;
      w_held_reg  <= 1'b0;
      wdata_reg   <= 32'h0;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `AXI_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= `AXI_OKAY;
      st_reg      <= ST_IDLE;
      cmd_reg     <= 18'h0;
      code_reg    <= HS_ACK;
      tmo_reg     <= 1'b0;
      rx_len_reg  <= 4'h0;
      rx_tog_reg  <= 1'b0;
      wait_reg    <= 5'd0;
    end else begin
      aw_held_reg <= aw_held_next;
      awaddr_reg  <= awaddr_next;
      w_held_reg  <= w_held_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      st_reg      <= st_next;
      cmd_reg     <= cmd_next;
      code_reg    <= code_next;
      tmo_reg     <= tmo_next;
      rx_len_reg  <= rx_len_next;
      rx_tog_reg  <= rx_tog_next;
      wait_reg    <= wait_next;
    end
  end

  irq_sticky #(
    .N (`HOST_IRQ_W)
  ) u_irq (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .set       (evt),
    .clr_we    (do_wr && (awaddr_reg == `H_IST_OFS) && wstrb_reg[0]),
    .clr_bits  (wdata_reg[`HOST_IRQ_W-1:0]),
    .mask_we   (do_wr && (awaddr_reg == `H_IMSK_OFS) && wstrb_reg[0]),
    .mask_bits (wdata_reg[`HOST_IRQ_W-1:0]),
    .status    (ist),
    .mask      (imsk),
    .irq       (irq)
  );

  // token drive: one cycle per token, fields from the command word
  assign link.tok_valid = (st_reg == ST_TOKEN) || (st_reg == ST_HACK);
  assign link.tok_pid   = (st_reg == ST_HACK) ? PID_HACK : pid_t'(cmd_reg[1:0]);
  assign link.tok_tog   = cmd_reg[`CMD_TOG];
  assign link.tok_ep    = cmd_reg[6:3];
  assign link.tok_addr  = cmd_reg[13:7];
  assign link.tok_len   = cmd_reg[17:14];
  assign s_axi_awready  = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready   = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid   = bvalid_reg;
  assign s_axi_bresp    = bresp_reg;
  assign s_axi_arready  = !rvalid_reg;
  assign s_axi_rvalid   = rvalid_reg;
  assign s_axi_rdata    = rdata_reg;
  assign s_axi_rresp    = rresp_reg;
endmodule
`default_nettype wire

// ---- tb/usb_ep0_props.sv ----
// link checks between the host end and the endpoint-0 end
`default_nettype none
module usb_ep0_props (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               tok_valid,
  input wire usb_ep0_pkg::pid_t  tok_pid,
  input wire logic               ans_valid,
  input wire usb_ep0_pkg::code_t ans_code,
  input wire logic [3:0]         ans_len
);
  import usb_ep0_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////
  // answer is a pulse
  ans_pulse_a: assert property (ans_valid |=> !ans_valid)
    else $error("answer held too long");
  ans_cause_a: assert property (ans_valid |-> $past(tok_valid) && $past(tok_pid) != PID_HACK)
    else $error("answer without token");
  setup_ack_a: assert property (tok_valid && tok_pid == PID_SETUP ##1 ans_valid |-> ans_code == HS_ACK)
    else $error("setup not acked");
  in_code_a: assert property (tok_valid && tok_pid == PID_IN ##1 ans_valid |-> ans_code != HS_ACK)
    else $error("in answered with ack");
  out_code_a: assert property (tok_valid && tok_pid == PID_OUT ##1 ans_valid |-> ans_code != HS_DATA)
    else $error("out answered with data");
  hack_follow_a: assert property (ans_valid && ans_code == HS_DATA |=> tok_valid && tok_pid == PID_HACK)
    else $error("data not acknowledged");
  hack_cause_a: assert property (tok_valid && tok_pid == PID_HACK |-> $past(ans_valid) && $past(ans_code) == HS_DATA)
    else $error("stray host ack");
  // answer fields hold; skip the edge right after reset
  code_hold_a: assert property (!ans_valid && $past(aresetn) |-> $stable(ans_code) && $stable(ans_len))
    else $error("answer fields moved");
  cover property (ans_valid && ans_code == HS_DATA);
  cover property (ans_valid && ans_code == HS_STALL);
  cover property (ans_valid && ans_code == HS_NAK);
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench: host end and endpoint-0 end joined by the link
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import usb_ep0_pkg::*;
  localparam logic [2:0] TMO = 3'h4;
  logic        aclk = 1'h0, aresetn = 1'h0, fw_wr = 1'h0, fw_rd = 1'h0, dirq, hirq;
  logic [15:0] fw_addr = 16'h0, buf_base;
  logic [7:0]  fw_wdata = 8'h0, fw_rdata;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0, rdata, st;
  logic [1:0]  bresp, rresp;
  int          n_errors = 0, n_tests = 0, cyc = 0;
  always #12.5 aclk = ~aclk;
  usb_link_if link (.aclk(aclk), .aresetn(aresetn));
  usb_ep0_dev u_usb_ep0_dev (.aclk(aclk), .aresetn(aresetn), .link(link), .fw_addr(fw_addr),
    .fw_wr(fw_wr), .fw_rd(fw_rd), .fw_wdata(fw_wdata), .fw_rdata(fw_rdata),
    .buf_base(buf_base), .irq(dirq));
  usb_ep0_host u_usb_ep0_host (.aclk(aclk), .aresetn(aresetn), .link(link),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(hirq));
  usb_ep0_props u_usb_ep0_props (.aclk(aclk), .aresetn(aresetn), .tok_valid(link.tok_valid),
    .tok_pid(link.tok_pid), .ans_valid(link.ans_valid), .ans_code(link.ans_code),
    .ans_len(link.ans_len));
  //////////////////////////////////////////////
  // firmware port: one strobe cycle each
  task automatic fww(input logic [15:0] a, input logic [7:0] d);
    @(posedge aclk);
    fw_addr <= a;
    fw_wr <= 1'h1;
    fw_wdata <= d;
    @(posedge aclk);
    fw_wr <= 1'h0;
    #1;
  endtask
  task automatic fwr(input logic [15:0] a, input logic [7:0] e);
    @(posedge aclk);
    fw_addr <= a;
    fw_rd <= 1'h1;
    @(posedge aclk);
    fw_rd <= 1'h0;
    #1;
    `CHK("fw_rdata", e, fw_rdata)
  endtask
  // axi write: each channel released only when taken
  task automatic aw(input logic [3:0] a, input logic [31:0] d);
    bit ta = 0, tw = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= d;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ta = 1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready) begin
        tw = 1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'h0;
    #1;
  endtask
  task automatic ar(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'h0;
    st = rdata;
    #1;
  endtask
  // one host transaction, polled until idle
  task automatic txn(input pid_t p, input logic t, input logic [6:0] a,
                     input logic [3:0] l, input logic [2:0] e);
    aw(4'h0, {14'h0, l, a, 4'h0, t, p});
    do ar(4'h4); while (st[0]);
    if (e[2]) `CHK("timeout", 1'h1, st[3])
    else `CHK("code", e[1:0], st[2:1])
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // cycle ceiling well above the expected run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      give_verdict();
    end
  end
  // test sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    fwr(16'hFF81, 8'h80);
    fwr(16'hFF83, 8'h80);
    fwr(16'hFF82, 8'h00);
    fwr(16'hFF93, 8'h00);
    $display("done reset values");
    fww(16'hFF93, 8'hFF);
    fwr(16'hFF93, 8'h7F);
    txn(PID_OUT, 1'h0, 7'h7E, 4'h3, TMO);
    txn(PID_OUT, 1'h0, 7'h7F, 4'h3, HS_NAK);
    `CHK("host irq", 1'h0, hirq)
    aw(4'hC, 32'h1);
    `CHK("host irq", 1'h1, hirq)
    `CHK("bresp", 2'h0, bresp)
    ar(4'hC);
    `CHK("imask", 32'h1, st)
    aw(4'h8, 32'h3);
    `CHK("host irq", 1'h0, hirq)
    aw(4'h4, 32'h0);
    `CHK("bresp", 2'h2, bresp)
    ar(4'h1);
    `CHK("rresp", 2'h2, rresp)
    `CHK("rdata", 32'h0, st)
    $display("done address");
    fww(16'hFF82, 8'h84);
    fww(16'hFF83, 8'h00);
    fww(16'hFF95, 8'h02);
    txn(PID_OUT, 1'h0, 7'h7F, 4'h9, HS_ACK);
    fwr(16'hFF83, 8'h89);
    fwr(16'hFF82, 8'hA4);
    `CHK("buf_base", 16'hFEF0, buf_base)
    `CHK("dev irq", 1'h1, dirq)
    fww(16'hFF94, 8'h02);
    `CHK("dev irq", 1'h0, dirq)
    txn(PID_OUT, 1'h1, 7'h7F, 4'h2, HS_NAK);
    $display("done out");
    txn(PID_IN, 1'h0, 7'h7F, 4'h0, HS_NAK);
    fww(16'hFF81, 8'h07);
    txn(PID_IN, 1'h0, 7'h7F, 4'h0, HS_DATA);
    `CHK("rx len", 4'h7, st[7:4])
    fwr(16'hFF81, 8'h87);
    `CHK("buf_base", 16'hFEF8, buf_base)
    $display("done in");
    fww(16'hFF82, 8'h8C);
    txn(PID_OUT, 1'h1, 7'h7F, 4'h1, HS_STALL);
    fwr(16'hFF82, 8'hA4);
    txn(PID_SETUP, 1'h0, 7'h7F, 4'h0, HS_ACK);
    fww(16'hFF81, 8'h00);
    txn(PID_IN, 1'h0, 7'h7F, 4'h0, HS_NAK);
    fww(16'hFF94, 8'h01);
    txn(PID_IN, 1'h0, 7'h7F, 4'h0, HS_DATA);
    `CHK("rx len", 4'h0, st[7:4])
    `CHK("rx tog", 1'h1, st[8])
    fww(16'hFF83, 8'h00);
    txn(PID_OUT, 1'h0, 7'h7F, 4'h5, HS_ACK);
    fwr(16'hFF83, 8'h00);
    txn(PID_OUT, 1'h1, 7'h7F, 4'h5, HS_ACK);
    fwr(16'hFF83, 8'h85);
    `CHK("buf_base", 16'hFEF0, buf_base)
    $display("done stall and setup");
    give_verdict();
  end
endmodule
`default_nettype wire
